// File: alu_tail_pkg.sv
// Shared constants and types for the subtract, swap and XOR execute block.
// Assumes a 32-bit AXI4-Lite register bus and an 8-bit accumulator datapath.
`default_nettype none
package alu_tail_pkg;

  // ----------------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFF_COMMAND   = 8'h00;
  localparam logic [7:0] OFF_ACCUM     = 8'h04;
  localparam logic [7:0] OFF_STATUS    = 8'h08;
  localparam logic [7:0] OFF_FILE_PTR  = 8'h0C;
  localparam logic [7:0] OFF_FILE_DATA = 8'h10;
  localparam logic [7:0] OFF_DIRECTION = 8'h14;
  localparam logic [7:0] OFF_WATCHDOG  = 8'h18;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int CMD_OP_LSB    = 0;
  localparam int CMD_DEST_BIT  = 4;
  localparam int CMD_FILE_LSB  = 8;
  localparam int CMD_LIT_LSB   = 16;
  localparam int ST_CARRY      = 0;
  localparam int ST_NIBBLE     = 1;
  localparam int ST_ZERO       = 2;
  localparam int ST_EXPIRED    = 3;
  localparam int ST_SLEPT      = 4;

  // ----------------------------------------------------------------------
  // Reset values and operand codes
  // ----------------------------------------------------------------------
  localparam logic [7:0] ACC_RESET  = 8'h00;
  localparam logic [7:0] DIR_RESET  = 8'hFF;
  localparam logic [7:0] WDT_CLEAR  = 8'h00;
  localparam logic [7:0] PRE_CLEAR  = 8'h00;
  localparam logic [6:0] DIR_A_SEL  = 7'h05;
  localparam logic [6:0] DIR_B_SEL  = 7'h06;
  localparam logic [6:0] DIR_C_SEL  = 7'h07;
  localparam logic [1:0] RESP_OKAY  = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Operation codes carried in the command register
  typedef enum logic [3:0] {
    no_op                   = 4'h0,
    literal_subtract_op     = 4'h1,
    file_subtract_op        = 4'h2,
    subtract_with_borrow_op = 4'h3,
    nibble_swap_op          = 4'h4,
    direction_load_op       = 4'h5,
    literal_exclusive_or_op = 4'h6,
    file_exclusive_or_op    = 4'h7,
    sleep_op                = 4'h8
  } op_e;

  // Command word in its bus layout; spare bits are kept but never decoded
  typedef struct packed {
    logic [7:0] literal;
    logic       spare_hi;
    logic [6:0] file_addr;
    logic [2:0] spare_lo;
    logic       dest_file;
    op_e        op;
  } cmd_s;

  // Status flags
  typedef struct packed {
    logic sleep_entered_flag;
    logic watchdog_expired_flag;
    logic zero;
    logic nibble_borrow_flag;
    logic carry;
  } status_s;

  // Result of one subtraction
  typedef struct packed {
    logic [7:0] diff;
    logic       carry;
    logic       nibble;
  } sub_s;

endpackage
`default_nettype wire

// File: subtract_swap_xor_execute.sv
// Execute stage for the subtract, nibble swap, XOR, direction load and sleep
// operations of an 8-bit core, with its accumulator, file and flags.
// Assumes an AXI4-Lite master with one write and one read outstanding.
// Summary of operation
// - Literal subtract puts literal minus accumulator into the accumulator.
// - Subtracts set carry and nibble flag unless accumulator part plus any borrow-in exceeds other operand.
// - Sleep clears watchdog counter and prescaler, sets expired, clears sleep-entered.
// - File subtract computes file minus accumulator, destination bit picks target.
// - Subtract with borrow also removes inverted carry, destination bit picks target.
// - Nibble swap exchanges file nibbles into destination, flags unchanged.
// - Direction load copies accumulator to port A, B or C for operand 5-7.
// - Literal XOR puts accumulator XOR literal in accumulator, zero flag only.
// - File XOR with accumulator goes to chosen destination, zero flag only.
`timescale 1ns/1ps
`default_nettype none

module subtract_swap_xor_execute #(
  parameter int FILE_DEPTH = 128
) (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Write address channel
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output var  logic        s_axi_awready,
  // Write data channel
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output var  logic        s_axi_wready,
  // Write response channel
  output var  logic [1:0]  s_axi_bresp,
  output var  logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // Read address channel
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output var  logic        s_axi_arready,
  // Read data channel
  output var  logic [31:0] s_axi_rdata,
  output var  logic [1:0]  s_axi_rresp,
  output var  logic        s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  // ----------------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------------
  // File addresses are seven bits wide, so more entries cannot be reached
  if (FILE_DEPTH < 8 || FILE_DEPTH > 128) begin : g_depth_check
    $error("FILE_DEPTH must lie between 8 and 128");
  end

  // ----------------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------------
  // Two's complement a - b - !cin, with carry meaning no borrow
  function automatic alu_tail_pkg::sub_s subtract(input logic [7:0] a,
                                                   input logic [7:0] b,
                                                   input logic       cin);
    logic [8:0] full;
    logic [4:0] low;
    full = {1'b0, a} + {1'b0, ~b} + {8'h00, cin};
    low  = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + {4'h0, cin};
    return '{diff: full[7:0], carry: full[8], nibble: low[4]};
  endfunction

  // Byte-lane merge of a bus write into a stored value
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wr,
                                        input logic [3:0]  strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = wr[8*i +: 8];
      end
    end
    return res;
  endfunction

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  logic                  aw_full_q;
  logic                  w_full_q;
  logic [7:0]            waddr_q;
  logic [31:0]           wdata_q;
  logic [3:0]            wstrb_q;
  logic                  exec_q;
  alu_tail_pkg::cmd_s    cmd_q;
  logic [7:0]            acc_q;
  alu_tail_pkg::status_s status_q;
  logic [6:0]            file_ptr_q;
  logic [7:0]            file_q [FILE_DEPTH];
  logic [7:0]            dir_a_q;
  logic [7:0]            dir_b_q;
  logic [7:0]            dir_c_q;
  logic [7:0]            watchdog_counter_q;
  logic [7:0]            prescaler_q;
  logic                  do_write;
  logic [31:0]           cmd_word;
  logic [7:0]            file_val;
  logic [7:0]            result;
  logic                  to_file;
  logic                  to_acc;
  alu_tail_pkg::sub_s    sub_res;

  assign do_write = aw_full_q && w_full_q && !s_axi_bvalid;
  // Byte lanes not strobed keep the previous command fields
  assign cmd_word = merge({8'h00, cmd_q}, wdata_q, wstrb_q);

  // ----------------------------------------------------------------------
  // Write channels: each address and data taken once, in either order
  // ----------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      aw_full_q     <= 1'b0;
      waddr_q       <= 8'h00;
    end else begin
      s_axi_awready <= s_axi_awvalid && !s_axi_awready && !aw_full_q && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_q <= 1'b1;
        waddr_q   <= s_axi_awaddr;
      end else if (do_write) begin
        aw_full_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_wready <= 1'b0;
      w_full_q     <= 1'b0;
      wdata_q      <= 32'h0000_0000;
      wstrb_q      <= 4'h0;
    end else begin
      s_axi_wready <= s_axi_wvalid && !s_axi_wready && !w_full_q && !s_axi_bvalid;
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end else if (do_write) begin
        w_full_q <= 1'b0;
      end
    end
  end

  // Response follows the register update; unmapped offsets answer SLVERR
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= alu_tail_pkg::RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (waddr_q > alu_tail_pkg::OFF_WATCHDOG || waddr_q[1:0] != 2'h0) ?
                      alu_tail_pkg::RESP_SLVERR : alu_tail_pkg::RESP_OKAY;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Command capture: a command write executes on the next edge
  // ----------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      exec_q <= 1'b0;
      cmd_q  <= '0;
    end else begin
      exec_q <= do_write && waddr_q == alu_tail_pkg::OFF_COMMAND && wstrb_q[0];
      if (do_write && waddr_q == alu_tail_pkg::OFF_COMMAND) begin
        cmd_q <= alu_tail_pkg::cmd_s'(cmd_word[23:0]);
      end
    end
  end

  // ----------------------------------------------------------------------
  // Datapath
  // ----------------------------------------------------------------------
  // Borrow-in is the inverted carry only for the subtract-with-borrow form
  always_comb begin
    file_val = file_q[cmd_q.file_addr];
    result   = 8'h00;
    to_file  = 1'b0;
    to_acc   = 1'b0;
    sub_res  = subtract(file_val, acc_q,
                        (cmd_q.op == alu_tail_pkg::subtract_with_borrow_op) ? status_q.carry : 1'b1);
    unique case (cmd_q.op)
      alu_tail_pkg::literal_subtract_op: begin
        sub_res = subtract(cmd_q.literal, acc_q, 1'b1);
        result  = sub_res.diff;
        to_acc  = 1'b1;
      end
      alu_tail_pkg::file_subtract_op,
      alu_tail_pkg::subtract_with_borrow_op: begin
        result  = sub_res.diff;
        to_file = cmd_q.dest_file;
        to_acc  = !cmd_q.dest_file;
      end
      alu_tail_pkg::nibble_swap_op: begin
        result  = {file_val[3:0], file_val[7:4]};
        to_file = cmd_q.dest_file;
        to_acc  = !cmd_q.dest_file;
      end
      alu_tail_pkg::literal_exclusive_or_op: begin
        result = acc_q ^ cmd_q.literal;
        to_acc = 1'b1;
      end
      alu_tail_pkg::file_exclusive_or_op: begin
        result  = acc_q ^ file_val;
        to_file = cmd_q.dest_file;
        to_acc  = !cmd_q.dest_file;
      end
      default: begin
        result = 8'h00;
      end
    endcase
  end

  // Accumulator: execution wins over a bus write, which cannot coincide anyway
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acc_q <= alu_tail_pkg::ACC_RESET;
    end else if (exec_q && to_acc) begin
      acc_q <= result;
    end else if (do_write && waddr_q == alu_tail_pkg::OFF_ACCUM && wstrb_q[0]) begin
      acc_q <= wdata_q[7:0];
    end
  end

  // File registers and the bus pointer into them
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      file_ptr_q <= 7'h00;
      for (int i = 0; i < FILE_DEPTH; i++) begin
        file_q[i] <= 8'h00;
      end
    end else begin
      if (exec_q && to_file) begin
        file_q[cmd_q.file_addr] <= result;
      end else if (do_write && wstrb_q[0] && waddr_q == alu_tail_pkg::OFF_FILE_DATA) begin
        file_q[file_ptr_q] <= wdata_q[7:0];
      end
      if (do_write && wstrb_q[0] && waddr_q == alu_tail_pkg::OFF_FILE_PTR) begin
        file_ptr_q <= wdata_q[6:0];
      end
    end
  end

  // Status flags: only the operations that own a flag may touch it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_q <= '0;
    end else if (exec_q) begin
      unique case (cmd_q.op)
        alu_tail_pkg::literal_subtract_op,
        alu_tail_pkg::file_subtract_op,
        alu_tail_pkg::subtract_with_borrow_op: begin
          status_q.carry              <= sub_res.carry;
          status_q.nibble_borrow_flag <= sub_res.nibble;
          status_q.zero               <= (result == 8'h00);
        end
        alu_tail_pkg::literal_exclusive_or_op,
        alu_tail_pkg::file_exclusive_or_op: begin
          status_q.zero <= (result == 8'h00);
        end
        alu_tail_pkg::sleep_op: begin
          status_q.watchdog_expired_flag <= 1'b1;
          status_q.sleep_entered_flag    <= 1'b0;
        end
        default: begin
          status_q <= status_q;
        end
      endcase
    end else if (do_write && wstrb_q[0] && waddr_q == alu_tail_pkg::OFF_STATUS) begin
      status_q <= alu_tail_pkg::status_s'(wdata_q[4:0]);
    end
  end

  // Port direction registers, loaded only for operands 5, 6 and 7
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dir_a_q <= alu_tail_pkg::DIR_RESET;
      dir_b_q <= alu_tail_pkg::DIR_RESET;
      dir_c_q <= alu_tail_pkg::DIR_RESET;
    end else if (exec_q && cmd_q.op == alu_tail_pkg::direction_load_op) begin
      if (cmd_q.file_addr == alu_tail_pkg::DIR_A_SEL) dir_a_q <= acc_q;
      if (cmd_q.file_addr == alu_tail_pkg::DIR_B_SEL) dir_b_q <= acc_q;
      if (cmd_q.file_addr == alu_tail_pkg::DIR_C_SEL) dir_c_q <= acc_q;
    end
  end

  // Free-running watchdog with an 8-bit prescaler; sleep restarts both
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prescaler_q        <= alu_tail_pkg::PRE_CLEAR;
      watchdog_counter_q <= alu_tail_pkg::WDT_CLEAR;
    end else if (exec_q && cmd_q.op == alu_tail_pkg::sleep_op) begin
      prescaler_q        <= alu_tail_pkg::PRE_CLEAR;
      watchdog_counter_q <= alu_tail_pkg::WDT_CLEAR;
    end else begin
      prescaler_q <= prescaler_q + 8'h01;
      if (prescaler_q == 8'hFF) watchdog_counter_q <= watchdog_counter_q + 8'h01;
    end
  end

  // ----------------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= alu_tail_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= alu_tail_pkg::RESP_OKAY;
        unique case (s_axi_araddr)
          alu_tail_pkg::OFF_COMMAND:   s_axi_rdata <= {8'h00, cmd_q};
          alu_tail_pkg::OFF_ACCUM:     s_axi_rdata <= {24'h000000, acc_q};
          alu_tail_pkg::OFF_STATUS:    s_axi_rdata <= {27'h0, 5'(status_q)};
          alu_tail_pkg::OFF_FILE_PTR:  s_axi_rdata <= {25'h0, file_ptr_q};
          alu_tail_pkg::OFF_FILE_DATA: s_axi_rdata <= {24'h000000, file_q[file_ptr_q]};
          alu_tail_pkg::OFF_DIRECTION: s_axi_rdata <= {8'h00, dir_c_q, dir_b_q, dir_a_q};
          alu_tail_pkg::OFF_WATCHDOG:  s_axi_rdata <= {16'h0000, prescaler_q, watchdog_counter_q};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= alu_tail_pkg::RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence run_op(alu_tail_pkg::op_e o);
    exec_q && cmd_q.op == o;
  endsequence

  sequence to_acc_seq;
    !cmd_q.dest_file;
  endsequence

  literal_sub_a: assert property (run_op(alu_tail_pkg::literal_subtract_op) |=>
    acc_q == 8'($past(cmd_q.literal) - $past(acc_q)))
    else $error("literal subtract result wrong");

  sub_carry_a: assert property (run_op(alu_tail_pkg::literal_subtract_op) |=>
    status_q.carry == ($past(acc_q) <= $past(cmd_q.literal)) &&
    status_q.nibble_borrow_flag == ($past(acc_q[3:0]) <= $past(cmd_q.literal[3:0])))
    else $error("subtract borrow flags wrong");

  sleep_entry_a: assert property (run_op(alu_tail_pkg::sleep_op) |=>
    watchdog_counter_q == 8'h00 && prescaler_q == 8'h00 &&
    status_q.watchdog_expired_flag && !status_q.sleep_entered_flag)
    else $error("sleep entry effects wrong");

  file_sub_a: assert property (run_op(alu_tail_pkg::file_subtract_op) ##0 to_acc_seq |=>
    acc_q == 8'($past(file_val) - $past(acc_q)))
    else $error("file subtract result wrong");

  borrow_sub_a: assert property (run_op(alu_tail_pkg::subtract_with_borrow_op) ##0 to_acc_seq |=>
    acc_q == 8'($past(file_val) - $past(acc_q) - 8'(!$past(status_q.carry))))
    else $error("subtract with borrow result wrong");

  swap_flags_a: assert property (run_op(alu_tail_pkg::nibble_swap_op) |=>
    $stable(status_q) &&
    ($past(cmd_q.dest_file) || acc_q == {$past(file_val[3:0]), $past(file_val[7:4])}))
    else $error("nibble swap wrong");

  dir_load_a: assert property (run_op(alu_tail_pkg::direction_load_op) ##0
    cmd_q.file_addr == alu_tail_pkg::DIR_B_SEL |=> dir_b_q == $past(acc_q) && $stable(status_q))
    else $error("direction load wrong");

  lit_xor_a: assert property (run_op(alu_tail_pkg::literal_exclusive_or_op) |=>
    acc_q == ($past(acc_q) ^ $past(cmd_q.literal)) && status_q.carry == $past(status_q.carry))
    else $error("literal xor wrong");

  file_xor_a: assert property (run_op(alu_tail_pkg::file_exclusive_or_op) |=>
    status_q.zero == ($past(acc_q ^ file_val) == 8'h00) &&
    status_q.nibble_borrow_flag == $past(status_q.nibble_borrow_flag))
    else $error("file xor wrong");

  zero_flag_a: assert property (run_op(alu_tail_pkg::file_subtract_op) |=>
    status_q.zero == ($past(file_val) == $past(acc_q)))
    else $error("zero flag wrong");

endmodule

`default_nettype wire

// File: subtract_swap_xor_execute_test.sv
// Self-checking bench for the subtract, swap and XOR execute block.
// Assumes the block's AXI4-Lite slave and the register map in alu_tail_pkg.
`timescale 1ns/1ps
`default_nettype none

module subtract_swap_xor_execute_test;
  // ----------------------------------------------------------------------
  // Stimulus and observation signals
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [3:0] op;
    logic       d;
    logic [7:0] lit;
    logic [7:0] acc;
    logic [7:0] f;
    logic [4:0] st;
  } row_s;

  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'h0;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, resp;
  logic [31:0] rdata, seen, dir_exp;
  logic [20:0] exp;
  int          mismatches = 0;
  int          n_tests = 0;
  row_s        rows [16];

  // Clock at 20 MHz
  always #25 aclk = ~aclk;

  subtract_swap_xor_execute i_dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready)
  );

  // ----------------------------------------------------------------------
  // Checking and bus tasks
  // ----------------------------------------------------------------------
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] got, input logic [31:0] want);
    n_tests++;
    if (got !== want) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", name, want, got);
    end
  endtask

  // Bounded waits: a hung handshake ends the run
  task automatic give_up(input int n);
    if (n >= 50) begin
      mismatches++;
      $display("wrong value handshake expected response seen none");
      report_and_stop();
    end
  endtask

  // Entered right after a rising edge; ends one edge after release
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
    int   n;
    logic aw_done;
    logic w_done;
    n = 0;
    aw_done = 1'b0;
    w_done = 1'b0;
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_done && w_done) && n < 50) begin
      @(posedge aclk);
      n++;
      if (!aw_done && awready) begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_done && wready) begin
        w_done = 1'b1;
        wvalid <= 1'b0;
      end
    end
    give_up(n);
    do begin
      @(posedge aclk);
      n++;
    end while (!bvalid && n < 50);
    give_up(n);
    resp = bresp;
    bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
    end while (!arready && n < 50);
    give_up(n);
    arvalid <= 1'b0;
    do begin
      @(posedge aclk);
      n++;
    end while (!rvalid && n < 50);
    give_up(n);
    d = rdata;
    resp = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axi_write(a, d, r);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    logic [1:0] r;
    axi_read(a, d, r);
  endtask

  // ----------------------------------------------------------------------
  // Reference model: returns {acc, file, status}
  // ----------------------------------------------------------------------
  // Subtract a - b - borrow, giving {diff, carry, nibble}; carry high means no borrow
  function automatic logic [9:0] sub8(input logic [7:0] a, input logic [7:0] b, input logic c);
    logic [8:0] t;
    logic [4:0] n;
    t = {1'b0, a} - {1'b0, b} - {8'h00, ~c};
    n = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, ~c};
    return {t[7:0], ~t[8], ~n[4]};
  endfunction

  function automatic logic [20:0] model(input row_s r);
    logic [9:0] s;
    logic [7:0] a;
    logic [7:0] f;
    logic [4:0] st;
    a = r.acc;
    f = r.f;
    st = r.st;
    case (r.op)
      4'h1: s = sub8(r.lit, r.acc, 1'b1);
      4'h2: s = sub8(r.f, r.acc, 1'b1);
      4'h3: s = sub8(r.f, r.acc, r.st[0]);
      4'h4: s = {r.f[3:0], r.f[7:4], 2'b00};
      4'h6: s = {r.acc ^ r.lit, 2'b00};
      4'h7: s = {r.acc ^ r.f, 2'b00};
      default: return {a, f, st};
    endcase
    if (r.op inside {4'h1, 4'h2, 4'h3}) st[1:0] = {s[0], s[1]};
    if (r.op != 4'h4) st[2] = (s[9:2] == 8'h00);
    if (r.op == 4'h1 || r.op == 4'h6 || !r.d) a = s[9:2];
    else f = s[9:2];
    return {a, f, st};
  endfunction

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    // Borrow edges, both destinations, both carry-in values, zero results
    rows = '{'{4'h1, 1'b0, 8'h05, 8'h06, 8'h00, 5'h00}, '{4'h1, 1'b0, 8'h3C, 8'h3C, 8'h00, 5'h00},
             '{4'h1, 1'b0, 8'h20, 8'h01, 8'h00, 5'h00}, '{4'h2, 1'b0, 8'h00, 8'h10, 8'h25, 5'h00},
             '{4'h2, 1'b1, 8'h00, 8'h30, 8'h25, 5'h07}, '{4'h3, 1'b1, 8'h00, 8'h10, 8'h20, 5'h01},
             '{4'h3, 1'b0, 8'h00, 8'h10, 8'h20, 5'h00}, '{4'h3, 1'b1, 8'h00, 8'h00, 8'h00, 5'h04},
             '{4'h4, 1'b0, 8'h00, 8'h11, 8'hA5, 5'h07}, '{4'h4, 1'b1, 8'h00, 8'h11, 8'h3C, 5'h18},
             '{4'h6, 1'b0, 8'h5A, 8'h5A, 8'h00, 5'h03}, '{4'h6, 1'b0, 8'h0F, 8'hF0, 8'h00, 5'h04},
             '{4'h7, 1'b0, 8'h00, 8'h81, 8'h81, 5'h00}, '{4'h7, 1'b1, 8'h00, 8'h0F, 8'h33, 5'h1F},
             '{4'h0, 1'b0, 8'hFF, 8'h12, 8'h34, 5'h05}, '{4'h9, 1'b1, 8'hFF, 8'h12, 8'h34, 5'h05}};
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    // Table of operations, each on its own file register
    foreach (rows[i]) begin
      exp = model(rows[i]);
      wr(alu_tail_pkg::OFF_FILE_PTR, 32'(i + 16));
      wr(alu_tail_pkg::OFF_FILE_DATA, {24'h0, rows[i].f});
      wr(alu_tail_pkg::OFF_ACCUM, {24'h0, rows[i].acc});
      wr(alu_tail_pkg::OFF_STATUS, {27'h0, rows[i].st});
      wr(alu_tail_pkg::OFF_COMMAND, {8'h00, rows[i].lit, 1'b0, 7'(i + 16), 3'b000, rows[i].d, rows[i].op});
      rd(alu_tail_pkg::OFF_ACCUM, seen);
      check("accumulator", seen, {24'h0, exp[20:13]});
      rd(alu_tail_pkg::OFF_FILE_DATA, seen);
      check("file", seen, {24'h0, exp[12:5]});
      rd(alu_tail_pkg::OFF_STATUS, seen);
      check("status", seen, {27'h0, exp[4:0]});
    end
    $display("operation table done");
    // Direction load: selectors 4 and 8 lie outside the accepted range
    dir_exp = 32'h00FFFFFF;
    wr(alu_tail_pkg::OFF_STATUS, 32'h00000007);
    for (int s = 4; s <= 8; s++) begin
      wr(alu_tail_pkg::OFF_ACCUM, 32'(8'h30 + s));
      wr(alu_tail_pkg::OFF_COMMAND, {16'h0000, 1'b0, 7'(s), 8'h05});
      if (s >= 5 && s <= 7) dir_exp[8 * (s - 5) +: 8] = 8'(8'h30 + s);
      rd(alu_tail_pkg::OFF_DIRECTION, seen);
      check("direction", seen, dir_exp);
    end
    rd(alu_tail_pkg::OFF_STATUS, seen);
    check("direction flags", seen, 32'h00000007);
    $display("direction load done");
    // Sleep once the watchdog counter has advanced
    repeat (300) @(posedge aclk);
    rd(alu_tail_pkg::OFF_WATCHDOG, seen);
    check("watchdog running", 32'(seen[7:0] != 8'h00), 32'h1);
    wr(alu_tail_pkg::OFF_STATUS, 32'h00000017);
    wr(alu_tail_pkg::OFF_COMMAND, 32'h00000008);
    rd(alu_tail_pkg::OFF_WATCHDOG, seen);
    check("watchdog cleared", {24'h0, seen[7:0]}, 32'h0);
    check("prescaler restarted", 32'(seen[15:8] < 8'h10), 32'h1);
    rd(alu_tail_pkg::OFF_STATUS, seen);
    check("sleep flags", seen, 32'h0000000F);
    $display("sleep done");
    // Unmapped and unaligned places answer with an error
    axi_write(8'h1C, 32'hFFFFFFFF, seen[1:0]);
    check("write unmapped", {30'h0, seen[1:0]}, {30'h0, alu_tail_pkg::RESP_SLVERR});
    axi_write(8'h06, 32'hFFFFFFFF, seen[1:0]);
    check("write unaligned", {30'h0, seen[1:0]}, {30'h0, alu_tail_pkg::RESP_SLVERR});
    axi_read(8'h40, seen, resp);
    check("read unmapped data", seen, 32'h0);
    check("read unmapped resp", {30'h0, resp}, {30'h0, alu_tail_pkg::RESP_SLVERR});
    $display("unmapped access done");
    // Reset in mid-run idles the handshakes and restores accumulator, status and direction
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    check("idle outputs", {27'h0, awready, wready, bvalid, arready, rvalid}, 32'h0);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(alu_tail_pkg::OFF_ACCUM, seen);
    check("accumulator reset", seen, 32'h0);
    rd(alu_tail_pkg::OFF_STATUS, seen);
    check("status reset", seen, 32'h0);
    rd(alu_tail_pkg::OFF_DIRECTION, seen);
    check("direction reset", seen, 32'h00FFFFFF);
    $display("reset done");
    report_and_stop();
  end
endmodule

`default_nettype wire
